// [rtl/cpf_clock_ctrl.sv]
// Purpose: trim register, system clock prescaler and clock failure detection
// Assumes: classic wishbone slave, 32-bit data, byte data in bits 7:0
// Notes:   the detector tick is derived here from the main clock
//
// Implementation choice: the Wishbone register port.
`include "cpf_params.svh"
`timescale 1ns/1ps
module cpf_clock_ctrl
    import cpf_pkg::*;
#(
    parameter logic [15:0] STARTUP_TICKS = `CPF_STARTUP_TICKS
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // fuses and straps
    input  wire logic [7:0]  factory_trim,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic        clock_fail_detect,
    // power state and external clock
    input  wire logic        sleep_deep,
    input  wire logic        ext_clock_in,
    // clock controls
    output logic [7:0]       rc_trim,
    output logic             trim_band_select,
    output logic [6:0]       trim_fine,
    output logic             sys_tick,
    output logic [3:0]       clock_source_select,
    output logic             rc_osc_enable,
    output logic             det_osc_enable,
    output logic             fail_irq
);

    cpf_acc_s   acc;
    cpf_ctl_s   ctl;
    cpf_mon_e   mon;
    logic       ack_q;
    logic       hit;
    logic [3:0] active_select;
    logic [2:0] window_count;
    logic       straps_taken;
    logic       ext_sync;
    logic       ext_prev;
    logic       sleep_sync;
    logic       det_tick;
    logic [7:0] det_div;
    logic [15:0] startup_count;
    logic [3:0] fail_ticks;
    logic       edge_seen;
    logic       failed;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic is_write(input cpf_acc_s a, input logic [7:0] idx);
        is_write = a.valid && a.we && (a.index == idx);
    endfunction : is_write

    function automatic logic [31:0] word(input logic [7:0] b);
        word = {24'h000000, b};
    endfunction : word

    // ****************************************************************
    // bus slave: ack one cycle after the request, err on unmapped index
    // ****************************************************************
    assign acc.valid = wb_cyc_i && wb_stb_i && !ack_q && wb_sel_i[0] && hit;
    assign acc.we    = wb_we_i;
    assign acc.wdata = wb_dat_i[7:0];
    assign acc.index = 8'(wb_adr_i[9:2]);
    assign hit       = (acc.index == `CPF_IDX_DIVIDER_CONTROL) || (acc.index == `CPF_IDX_FAIL_DETECT) ||
                       (acc.index == `CPF_IDX_RC_TRIM) || (acc.index == `CPF_IDX_STATUS);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_q    <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            ack_q    <= wb_cyc_i && wb_stb_i && !ack_q;
            wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_q && hit;
            wb_err_o <= wb_cyc_i && wb_stb_i && !ack_q && !hit;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
            case (acc.index)
                `CPF_IDX_DIVIDER_CONTROL: wb_dat_o <= word({ctl.change_en, 3'h0, ctl.divider_select});
                `CPF_IDX_FAIL_DETECT:     wb_dat_o <= word({6'h00, ctl.fail_flag, ctl.fail_ie});
                `CPF_IDX_RC_TRIM:         wb_dat_o <= word(rc_trim);
                `CPF_IDX_STATUS:          wb_dat_o <= word({2'h0, mon, active_select});
                default:                  wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // straps are caught after reset release
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            straps_taken <= 1'b0;
        end else begin
            straps_taken <= 1'b1;
        end
    end

    // ****************************************************************
    // oscillator trim
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rc_trim <= `CPF_TRIM_DEFAULT;
        end else if (!straps_taken) begin
            rc_trim <= factory_trim;
        end else if (is_write(acc, `CPF_IDX_RC_TRIM)) begin
            rc_trim <= acc.wdata;
        end
    end

    assign trim_band_select = rc_trim[7];
    assign trim_fine        = rc_trim[6:0];

    // ****************************************************************
    // divider control with timed change enable
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl.change_en <= 1'b0;
            window_count  <= 3'h0;
        end else if (is_write(acc, `CPF_IDX_DIVIDER_CONTROL) && ctl.change_en
                     && !acc.wdata[`CPF_CHANGE_EN_BIT]) begin
            ctl.change_en <= 1'b0;
            window_count  <= 3'h0;
        end else if (is_write(acc, `CPF_IDX_DIVIDER_CONTROL) && !ctl.change_en
                     && acc.wdata == `CPF_CHANGE_EN_WRITE) begin
            ctl.change_en <= 1'b1;
            window_count  <= `CPF_CHANGE_WINDOW;
        end else if (ctl.change_en) begin
            // a rewrite falls here and does not restart the window
            window_count  <= window_count - 3'h1;
            ctl.change_en <= (window_count != 3'h1);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl.divider_select <= `CPF_DIV_BY1;
        end else if (!straps_taken) begin
            ctl.divider_select <= divide_by_eight_fuse ? `CPF_DIV_BY8 : `CPF_DIV_BY1;
        end else if (failed && !ctl.fail_flag) begin
            // one cycle only: the flag follows failed one edge later
            ctl.divider_select <= `CPF_DIV_BY8;
        end else if (is_write(acc, `CPF_IDX_DIVIDER_CONTROL) && ctl.change_en
                     && !acc.wdata[`CPF_CHANGE_EN_BIT]) begin
            // any code is stored, regardless of the fuse
            ctl.divider_select <= acc.wdata[`CPF_DIV_MSB:`CPF_DIV_LSB];
        end
    end

    // ****************************************************************
    // prescaler: reserved codes are held at the largest factor
    // ****************************************************************
    cpf_prescaler u_prescaler (
        .clock          (clock),
        .rst_b          (rst_b),
        .divider_select ((ctl.divider_select > `CPF_DIV_MAX) ? `CPF_DIV_MAX : ctl.divider_select),
        .sys_tick       (sys_tick),
        .active_select  (active_select)
    );

    // ****************************************************************
    // detector clock and inputs
    // ****************************************************************
    cpf_sync u_ext_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in (ext_clock_in),
        .sync_out (ext_sync)
    );

    cpf_sync u_sleep_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in (sleep_deep),
        .sync_out (sleep_sync)
    );

    assign det_osc_enable = clock_fail_detect;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            det_div  <= 8'h00;
            det_tick <= 1'b0;
        end else if (!det_osc_enable) begin
            det_div  <= 8'h00;
            det_tick <= 1'b0;
        end else if (det_div == 8'(`CPF_DET_PERIOD_CYC - 1)) begin
            det_div  <= 8'h00;
            det_tick <= 1'b1;
        end else begin
            det_div  <= det_div + 8'h01;
            det_tick <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_sync;
        end
    end

    // ****************************************************************
    // failure monitor
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mon           <= cpf_mon_off;
            startup_count <= 16'h0000;
            fail_ticks    <= 4'h0;
            edge_seen     <= 1'b0;
            failed        <= 1'b0;
        end else begin
            case (mon)
                cpf_mon_off: begin
                    startup_count <= 16'h0000;
                    if (clock_fail_detect && !sleep_sync) begin
                        mon <= cpf_mon_startup;
                    end
                end
                cpf_mon_startup: begin
                    if (!clock_fail_detect || sleep_sync) begin
                        mon <= cpf_mon_off;
                    end else if (startup_count >= STARTUP_TICKS) begin
                        mon        <= cpf_mon_watch;
                        fail_ticks <= 4'h0;
                        edge_seen  <= 1'b0;
                    end else if (det_tick) begin
                        startup_count <= startup_count + 16'h0001;
                    end
                end
                cpf_mon_watch: begin
                    if (!clock_fail_detect || sleep_sync) begin
                        mon <= cpf_mon_off;
                    end else if (ext_sync && !ext_prev) begin
                        edge_seen <= 1'b1;
                        if (det_tick) begin
                            fail_ticks <= 4'h0;
                            edge_seen  <= 1'b0;
                        end
                    end else if (det_tick) begin
                        if (edge_seen) begin
                            fail_ticks <= 4'h0;
                        end else if (fail_ticks == `CPF_FAIL_WINDOW_TICKS - 4'h1) begin
                            failed <= 1'b1;
                            mon    <= cpf_mon_failed;
                        end else begin
                            fail_ticks <= fail_ticks + 4'h1;
                        end
                        edge_seen <= 1'b0;
                    end
                end
                cpf_mon_failed: begin
                    mon <= cpf_mon_failed;
                end
                default: begin
                    mon <= cpf_mon_off;
                end
            endcase
        end
    end

    // ****************************************************************
    // clock switch
    // ****************************************************************
    assign clock_source_select = failed ? `CPF_SRC_RC : `CPF_SRC_EXT;
    assign rc_osc_enable       = failed;

    // ****************************************************************
    // fail detect control and status
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl.fail_flag <= 1'b0;
        end else if (failed) begin
            ctl.fail_flag <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl.fail_ie <= 1'b0;
        end else if (is_write(acc, `CPF_IDX_FAIL_DETECT) && acc.wdata[`CPF_FAIL_IE_BIT]) begin
            ctl.fail_ie <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fail_irq <= 1'b0;
        end else begin
            fail_irq <= ctl.fail_flag && ctl.fail_ie;
        end
    end

endmodule : cpf_clock_ctrl

// [inc/cpf_params.svh]
// Purpose: constants of the clock prescale, trim and failover block
// Assumes: byte-wide registers on a 32-bit classic wishbone, one word each
// Notes:   the printed offsets are indices, the byte address is four times the index
`ifndef CPF_PARAMS_SVH
`define CPF_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CPF_IDX_DIVIDER_CONTROL   8'h61
`define CPF_IDX_FAIL_DETECT       8'h62
`define CPF_IDX_RC_TRIM           8'h66
`define CPF_IDX_STATUS            8'h70
`define CPF_ADDR_W                10

// ****************************************************************
// fields and values
// ****************************************************************
`define CPF_CHANGE_EN_BIT         7
`define CPF_DIV_LSB               0
`define CPF_DIV_MSB               3
`define CPF_FAIL_FLAG_BIT         1
`define CPF_FAIL_IE_BIT           0
`define CPF_DIV_BY1               4'h0
`define CPF_DIV_BY8               4'h3
`define CPF_DIV_MAX               4'h8
`define CPF_CHANGE_EN_WRITE       8'h80
`define CPF_TRIM_DEFAULT          8'h80
`define CPF_SRC_RC                4'h2
`define CPF_SRC_EXT               4'h0

// ****************************************************************
// timing
// ****************************************************************
`define CPF_CHANGE_WINDOW         3'h4
`define CPF_CLOCK_HZ              20000000
`define CPF_DET_HZ                128000
`define CPF_DET_PERIOD_CYC        ((`CPF_CLOCK_HZ + `CPF_DET_HZ - 1) / `CPF_DET_HZ)
`define CPF_FAIL_WINDOW_TICKS     4'h4
`define CPF_STARTUP_TICKS         16'h0100

`endif

// [inc/cpf_pkg.sv]
// Purpose: shared types of the clock prescale, trim and failover block
// Assumes: cpf_params.svh holds every number
// Notes:   none
package cpf_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        cpf_mon_off     = 2'b00,
        cpf_mon_startup = 2'b01,
        cpf_mon_watch   = 2'b11,
        cpf_mon_failed  = 2'b10
    } cpf_mon_e;

    typedef struct packed {
        logic       valid;
        logic       we;
        logic [7:0] wdata;
        logic [7:0] index;
    } cpf_acc_s;

    typedef struct packed {
        logic       fail_flag;
        logic       fail_ie;
        logic [3:0] divider_select;
        logic       change_en;
    } cpf_ctl_s;

endpackage : cpf_pkg

// [rtl/cpf_sync.sv]
// Purpose: two-stage synchroniser for a level from outside the clock domain
// Assumes: one destination clock
// Notes:   only the second stage is visible
`timescale 1ns/1ps
module cpf_sync
    import cpf_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // level
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : cpf_sync

// [rtl/cpf_prescaler.sv]
// Purpose: glitch-free power-of-two divider of the source clock as an enable
// Assumes: divider_select already limited to legal codes
// Notes:   a new setting takes effect only at a terminal count of the old one
`include "cpf_params.svh"
`timescale 1ns/1ps
module cpf_prescaler
    import cpf_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // setting
    input  wire logic [3:0] divider_select,
    // output
    output logic            sys_tick,
    output logic [3:0]      active_select
);

    logic [7:0] count;
    logic [7:0] span;

    // ****************************************************************
    // divider
    // ****************************************************************
    assign span = 8'((9'h001 << active_select) - 9'h001);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count         <= 8'h00;
            active_select <= `CPF_DIV_BY1;
            sys_tick      <= 1'b0;
        end else if (count >= span) begin
            // switch only at the end of a full period: no short pulse
            count         <= 8'h00;
            active_select <= divider_select;
            sys_tick      <= 1'b1;
        end else begin
            count         <= count + 8'h01;
            sys_tick      <= 1'b0;
        end
    end

endmodule : cpf_prescaler

// [test/cpf_ext_osc.sv]
// Purpose: external oscillator on the far side of the failure detector
// Assumes: free running while run is high
// Notes:   a stopped oscillator stands at its last level, as a dead crystal does
`timescale 1ns/1ps
module cpf_ext_osc #(
    parameter int HALF_NS = 487
) (
    // control
    input  wire logic run,
    // clock out
    output logic      ext_clock
);
    // ****************************************************************
    // oscillator
    // ****************************************************************
    initial begin
        ext_clock = 1'b0;
        forever begin
            #(HALF_NS); // about 1 MHz, well above the detector minimum
            if (run) begin
                ext_clock = ~ext_clock;
            end
        end
    end
endmodule : cpf_ext_osc

// [test/cpf_clock_ctrl_monitor.sv]
// Purpose: port checker of the clock control block
// Assumes: bound to every instance of cpf_clock_ctrl
// Notes:   quiet counts cycles without an external clock change
`include "cpf_params.svh"
`timescale 1ns/1ps
module cpf_clock_ctrl_monitor #(
    parameter logic [15:0] STARTUP_TICKS = 16'h0100
) (
    input wire logic        clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o, wb_err_o,
    input wire logic [7:0]  rc_trim,
    input wire logic        trim_band_select,
    input wire logic [6:0]  trim_fine,
    input wire logic        sys_tick,
    input wire logic [3:0]  clock_source_select,
    input wire logic        rc_osc_enable, det_osc_enable, clock_fail_detect, ext_clock_in, fail_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic        map_ok;
    logic        ext_q;
    logic        seen;
    logic [15:0] quiet;
    logic [8:0]  gap;
    assign map_ok = wb_adr_i[9:2] inside {`CPF_IDX_DIVIDER_CONTROL, `CPF_IDX_FAIL_DETECT,
                                          `CPF_IDX_RC_TRIM, `CPF_IDX_STATUS};
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_q <= 1'b0;
            quiet <= 16'h0000;
        end else begin
            ext_q <= ext_clock_in;
            quiet <= (ext_clock_in != ext_q) ? 16'h0000 : quiet + {15'h0000, quiet != 16'hffff};
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap  <= 9'h000;
            seen <= 1'b0;
        end else begin
            seen <= seen | sys_tick;
            gap  <= sys_tick ? 9'h001 : gap + {8'h00, gap != 9'h1ff};
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    a_bus_ack: assert property (s_req ##0 map_ok |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acked");
    a_bus_err: assert property (s_req ##0 !map_ok |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");
    a_trim_write: assert property (s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == `CPF_IDX_RC_TRIM)
        |=> rc_trim == $past(wb_dat_i[7:0])) else $error("trim write lost");
    a_trim_split: assert property (trim_band_select == rc_trim[7] && trim_fine == rc_trim[6:0])
        else $error("trim fields wrong");
    a_det_osc: assert property (det_osc_enable == clock_fail_detect)
        else $error("detector oscillator enable wrong");
    a_rc_source: assert property (rc_osc_enable == (clock_source_select == `CPF_SRC_RC))
        else $error("fallback source and enable disagree");
    a_fail_sticky: assert property (rc_osc_enable |=> rc_osc_enable)
        else $error("fallback left without reset");
    a_irq_level: assert property (fail_irq |-> rc_osc_enable ##1 fail_irq)
        else $error("interrupt without failure or not held");
    a_fail_quiet: assert property ($rose(rc_osc_enable) |-> quiet >= 16'd471 && clock_fail_detect)
        else $error("failure declared while clock active");
    a_tick_gap: assert property (sys_tick && seen |-> gap inside {1, 2, 4, 8, 16, 32, 64, 128, 256})
        else $error("system tick spacing not a legal factor");
endmodule : cpf_clock_ctrl_monitor

bind cpf_clock_ctrl cpf_clock_ctrl_monitor #(.STARTUP_TICKS(STARTUP_TICKS)) u_mon (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .rc_trim(rc_trim), .trim_band_select(trim_band_select), .trim_fine(trim_fine), .sys_tick(sys_tick),
    .clock_source_select(clock_source_select), .rc_osc_enable(rc_osc_enable), .det_osc_enable(det_osc_enable),
    .clock_fail_detect(clock_fail_detect), .ext_clock_in(ext_clock_in), .fail_irq(fail_irq));

// [test/clock_prescale_trim_failover_test.sv]
// Purpose: self-checking bench of the clock control block
// Assumes: one byte per access, 20 MHz clock, start-up of 2 detector ticks
// Notes:   table rows are {write, index, data or expected read}
`include "cpf_params.svh"
`timescale 1ns/1ps
module clock_prescale_trim_failover_test;
    import cpf_pkg::*;
    logic        clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
    logic [9:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0]  rc_trim;
    logic [6:0]  trim_fine;
    logic [3:0]  clock_source_select;
    logic        fuse8, sleep_deep, ext_clock_in, osc_run, trim_band_select, sys_tick;
    logic        rc_osc_enable, det_osc_enable, fail_irq, cfd;
    int          err_total, tests_run, cyc_cnt, n;
    localparam logic [16:0] ROWS [0:26] = '{
        17'h0665a, 17'h06103, 17'h06200,             // reset values
        17'h1667f, 17'h0667f,                        // trim rewrite, no memory writes
        17'h16105, 17'h06103,                        // closed window
        17'h16181, 17'h16102, 17'h06103,             // enable write with other bits
        17'h16180, 17'h16108, 17'h06108,             // back-to-back sequence
        17'h16180, 17'h16180, 17'h16101, 17'h06108,  // rewrite does not extend
        17'h16180, 17'h1610f, 17'h0610f,             // reserved code kept
        17'h16180, 17'h16100, 17'h06100,
        17'h16201, 17'h16200, 17'h16203, 17'h06201};
    cpf_clock_ctrl #(.STARTUP_TICKS(16'h0002)) uut (
        .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .factory_trim(8'h5a), .divide_by_eight_fuse(fuse8), .clock_fail_detect(cfd),
        .sleep_deep(sleep_deep), .ext_clock_in(ext_clock_in), .rc_trim(rc_trim), .trim_band_select(trim_band_select),
        .trim_fine(trim_fine), .sys_tick(sys_tick), .clock_source_select(clock_source_select),
        .rc_osc_enable(rc_osc_enable), .det_osc_enable(det_osc_enable), .fail_irq(fail_irq));
    cpf_ext_osc #(.HALF_NS(487)) u_osc (.run(osc_run), .ext_clock(ext_clock_in));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt >= 40000) begin
            err_total++;
            finish_test();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {i, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task reset_dut(input logic f);
        fuse8 <= f;
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : reset_dut
    task wait_rc();
        n = 0;
        while (rc_osc_enable !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_rc
    task finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sleep_deep, fuse8} = 6'b000000;
        {wb_adr_i, wb_dat_i, osc_run} = 0;
        {err_total, tests_run, cyc_cnt} = 0;
        osc_run = 1'b1;
        cfd = 1'b1;
        reset_dut(1'b1);
        for (int k = 0; k < 27; k++) begin
            bus(ROWS[k][16], ROWS[k][15:8], ROWS[k][7:0]);
            if (!ROWS[k][16]) chk("row read", {24'h000000, ROWS[k][7:0]}, rd);
        end
        $display("test done: register table");
        chk("band low", 0, trim_band_select);
        chk("fine top", 32'h7f, trim_fine);
        bus(1'b1, `CPF_IDX_RC_TRIM, 8'h80);
        chk("band high", 1, trim_band_select);
        chk("fine bottom", 0, trim_fine);
        bus(1'b0, 8'h40, 8'h00);
        chk("unmapped err", 1, er);
        chk("no fallback", 0, rc_osc_enable);
        $display("test done: trim and refusal");
        // start-up time must be over before the clock dies
        repeat (400) @(posedge clock);
        osc_run <= 1'b0;
        wait_rc();
        chk("fail delay", 1, n >= 471 && n <= 800);
        repeat (2) @(posedge clock);
        chk("source rc", `CPF_SRC_RC, clock_source_select);
        chk("irq", 1, fail_irq);
        bus(1'b0, `CPF_IDX_DIVIDER_CONTROL, 8'h00);
        chk("forced div8", 32'h03, rd);
        bus(1'b0, `CPF_IDX_FAIL_DETECT, 8'h00);
        chk("flag set", 32'h03, rd);
        osc_run <= 1'b1;
        repeat (700) @(posedge clock);
        chk("stays fallback", 1, rc_osc_enable);
        $display("test done: failover");
        reset_dut(1'b0);
        chk("back to external", `CPF_SRC_EXT, clock_source_select);
        bus(1'b0, `CPF_IDX_DIVIDER_CONTROL, 8'h00);
        chk("div fuse off", 32'h00, rd);
        bus(1'b0, `CPF_IDX_FAIL_DETECT, 8'h00);
        chk("flag cleared", 32'h00, rd);
        repeat (1500) @(posedge clock);
        chk("healthy watch", 0, rc_osc_enable);
        sleep_deep <= 1'b1;
        osc_run <= 1'b0;
        repeat (1500) @(posedge clock);
        chk("sleep suspends", 0, rc_osc_enable);
        sleep_deep <= 1'b0;
        wait_rc();
        chk("wake restart", 1, n >= 700 && n <= 1500);
        repeat (2) @(posedge clock);
        chk("irq masked", 0, fail_irq);
        chk("det osc on", 1, det_osc_enable);
        cfd <= 1'b0;
        repeat (2) @(posedge clock);
        chk("det osc off", 0, det_osc_enable);
        $display("test done: reset and sleep");
        finish_test();
    end
endmodule : clock_prescale_trim_failover_test
